/* File: shared/oag_pkg.sv */
/*
  Constants and types for the operand address generator.
  Assumes an 8-bit data path, 8-bit data memory addresses within a segment,
  and a 15-bit program counter (upper byte uses 7 bits).
*/
package oag_pkg;

  localparam int DATA_W = 8;
  localparam int PC_W   = 15;
  localparam int PC_UPPER_W = 7;

  // pointer locations in the data memory map
  localparam logic [7:0] ADDR_X_PTR  = 8'hFC;
  localparam logic [7:0] ADDR_SP_PTR = 8'hFD;
  localparam logic [7:0] ADDR_B_PTR  = 8'hFE;

  localparam logic [7:0] RST_PTR = 8'h00;
  localparam logic [7:0] RST_SP  = 8'h6F;
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [3:0] HI_NIB_CLEAR = 4'h0;
  localparam logic [7:0] ONE_8   = 8'h01;

  typedef enum logic [2:0] {
    OAG_MODE_NONE,
    OAG_MODE_DIRECT,
    OAG_MODE_INDIRECT,
    OAG_MODE_INDIRECT_ADJ,
    OAG_MODE_IMMEDIATE,
    OAG_MODE_IMM_SHORT,
    OAG_MODE_TABLE
  } oag_mode_t;

  typedef enum logic [2:0] {
    OAG_OP_LOAD,
    OAG_OP_EXCHANGE,
    OAG_OP_BIT_SET,
    OAG_OP_BIT_CLEAR,
    OAG_OP_BIT_TEST,
    OAG_OP_STORE
  } oag_op_t;

endpackage : oag_pkg

/* File: rtl/oag_operand_addr.sv */
/*
  Operand address generator: resolves data/program operand addresses,
  keeps the two pointers, stack pointer and accumulator, and borrows the
  low program counter byte for table reads.
  Assumes the sequencer presents one decoded instruction per cycle with
  instr_valid, and that memories answer combinationally in the same cycle.
*/
// How it works
// (RULE1) a single-byte operand address is resolved combinationally, with no extra cycle.
// (RULE2) any data address bit can be set, cleared or tested through a bit index.
// (RULE3) the first pointer, second pointer and stack pointer live at data addresses.
// (RULE4) direct mode drives the instruction's address byte onto the data address.
// (RULE5) indirect mode drives the selected pointer's value onto the data address.
// (RULE6) indirect mode with adjust accesses at the old value, then steps that pointer.
// (RULE7) immediate mode takes the operand from the program byte after the opcode.
// (RULE8) the short load puts four bits into the first pointer's low nibble, high nibble zero.
// (RULE9) a table read puts the accumulator in place of the low program counter byte.
// (RULE10) the table read loads the fetched byte into the accumulator, program counter kept.
// (RULE11) only legal mode/operation pairs are taken; load accepts every operand mode except none.
// (RULE12) pointer adjust is by exactly one, wraps in eight bits, after the access.
// (RULE13) exchange writes the accumulator to memory and loads the old byte into it.
`timescale 1ns/1ps
module oag_operand_addr
  import oag_pkg::*;
(
  input  wire logic                  core_clk,        // core instruction clock
  input  wire logic                  sys_rst,         // synchronous reset, active high
  input  wire logic                  instr_valid,     // decoded instruction present
  input  wire oag_pkg::oag_mode_t    instr_mode,      // operand addressing mode
  input  wire oag_pkg::oag_op_t      instr_op,        // operation on the operand
  input  wire logic                  ptr_sel_second,  // 0 first pointer, 1 second
  input  wire logic                  adj_down,        // 1 decrement, 0 increment
  input  wire logic [7:0]            instr_addr,      // direct address byte
  input  wire logic [3:0]            instr_nibble,    // short immediate value
  input  wire logic [2:0]            bit_index,       // bit for bit operations
  input  wire logic [oag_pkg::PC_W-1:0] pc,           // program counter of the opcode
  input  wire logic [7:0]            prog_rdata,      // program memory read data
  input  wire logic [7:0]            data_rdata,      // data memory read data
  output logic [oag_pkg::PC_W-1:0]   prog_addr,       // program memory address
  output logic [7:0]                 data_addr,       // data memory address
  output logic                       data_rd,         // data memory read strobe
  output logic                       data_wr,         // data memory write strobe
  output logic [7:0]                 data_wdata,      // data memory write data
  output logic                       bit_result,      // tested bit value
  output logic                       instr_illegal,   // refused mode/op pairing
  output logic [7:0]                 acc,             // accumulator
  output logic [7:0]                 ptr_first,       // first pointer
  output logic [7:0]                 ptr_second,      // second pointer
  output logic [7:0]                 stack_ptr        // stack pointer
);
  import oag_pkg::*;

  // ==========================================================================
  // elaboration checks
  // ==========================================================================
  // the table read splices the accumulator under the upper pc bits, so the
  // pc must be exactly one data byte wider than its upper part
  if (PC_W <= DATA_W || PC_W - DATA_W != PC_UPPER_W)
  begin : g_width_check
    $error("program counter width does not fit the table read");
  end

  // ==========================================================================
  // legality and address resolution
  // ==========================================================================
  logic       legal;
  logic       take;
  logic [7:0] sel_ptr;
  logic       mem_mode;
  logic [7:0] mem_byte;
  logic [7:0] bit_mask;
  logic [7:0] ptr_hit_val;
  logic       ptr_hit;

  assign sel_ptr = ptr_sel_second ? ptr_second : ptr_first;

  // (RULE11) legal pairings
  always_comb
  begin
    legal = 1'b0;
    unique case (instr_mode)
      OAG_MODE_NONE:         legal = 1'b0;
      OAG_MODE_DIRECT:       legal = 1'b1;
      OAG_MODE_INDIRECT:     legal = 1'b1;
      OAG_MODE_INDIRECT_ADJ: legal = (instr_op == OAG_OP_LOAD) || (instr_op == OAG_OP_EXCHANGE);
      OAG_MODE_IMMEDIATE:    legal = (instr_op == OAG_OP_LOAD);
      OAG_MODE_IMM_SHORT:    legal = (instr_op == OAG_OP_LOAD);
      OAG_MODE_TABLE:        legal = (instr_op == OAG_OP_LOAD);
      default:               legal = 1'b0;
    endcase
  end

  assign take          = instr_valid && legal;
  assign instr_illegal = instr_valid && !legal;
  assign mem_mode      = (instr_mode == OAG_MODE_DIRECT) || (instr_mode == OAG_MODE_INDIRECT)
                      || (instr_mode == OAG_MODE_INDIRECT_ADJ);

  // (RULE1) combinational resolve
  always_comb
  begin
    data_addr = 8'h00;
    if (take && instr_mode == OAG_MODE_DIRECT)
      // (RULE4) direct byte
      data_addr = instr_addr;
    else if (take && mem_mode)
      // (RULE5) pointer as address
      data_addr = sel_ptr;
  end

  // pointers are memory mapped, so reads of their locations see live values
  // (RULE3) mapped pointers
  always_comb
  begin
    ptr_hit     = 1'b1;
    ptr_hit_val = 8'h00;
    unique case (data_addr)
      ADDR_X_PTR:  ptr_hit_val = ptr_second;
      ADDR_SP_PTR: ptr_hit_val = stack_ptr;
      ADDR_B_PTR:  ptr_hit_val = ptr_first;
      default:     ptr_hit = 1'b0;
    endcase
  end

  assign mem_byte = ptr_hit ? ptr_hit_val : data_rdata;
  assign bit_mask = ONE_8 << bit_index;

  assign data_rd = take && mem_mode;
  assign data_wr = take && mem_mode && !ptr_hit
                && (instr_op == OAG_OP_EXCHANGE || instr_op == OAG_OP_STORE
                 || instr_op == OAG_OP_BIT_SET || instr_op == OAG_OP_BIT_CLEAR);

  // (RULE2) bit set, clear, test
  always_comb
  begin
    data_wdata = acc;
    bit_result = 1'b0;
    unique case (instr_op)
      OAG_OP_BIT_SET:   data_wdata = mem_byte | bit_mask;
      OAG_OP_BIT_CLEAR: data_wdata = mem_byte & ~bit_mask;
      OAG_OP_BIT_TEST:  bit_result = take && mem_mode && |(mem_byte & bit_mask);
      // (RULE13) accumulator to memory
      default:          data_wdata = acc;
    endcase
  end

  // ==========================================================================
  // program memory address
  // ==========================================================================
  always_comb
  begin
    prog_addr = pc;
    if (take && instr_mode == OAG_MODE_IMMEDIATE)
      // (RULE7) byte after opcode
      prog_addr = pc + PC_W'(1);
    else if (take && instr_mode == OAG_MODE_TABLE)
      // (RULE9) accumulator as low byte
      prog_addr = {pc[PC_W-1:DATA_W], acc};
  end

  // ==========================================================================
  // accumulator
  // ==========================================================================
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      acc <= RST_ACC;
    else if (take)
    begin
      if (instr_mode == OAG_MODE_IMMEDIATE || instr_mode == OAG_MODE_TABLE)
        // (RULE10) fetched byte, pc not altered
        acc <= prog_rdata;
      else if (mem_mode && (instr_op == OAG_OP_LOAD || instr_op == OAG_OP_EXCHANGE))
        // (RULE13) old byte to accumulator
        acc <= mem_byte;
    end
  end

  // ==========================================================================
  // pointers; a mapped write to a pointer location lands here
  // ==========================================================================
  logic       wr_ptr;
  logic [7:0] adj_val;

  assign wr_ptr = take && mem_mode && ptr_hit
               && (instr_op == OAG_OP_EXCHANGE || instr_op == OAG_OP_STORE
                || instr_op == OAG_OP_BIT_SET || instr_op == OAG_OP_BIT_CLEAR);
  // (RULE12) step by one, wraps
  assign adj_val = adj_down ? sel_ptr - ONE_8 : sel_ptr + ONE_8;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      ptr_first <= RST_PTR;
    else if (take && instr_mode == OAG_MODE_IMM_SHORT)
      // (RULE8) nibble load
      ptr_first <= {HI_NIB_CLEAR, instr_nibble};
    else if (take && instr_mode == OAG_MODE_INDIRECT_ADJ && !ptr_sel_second)
      // (RULE6) post adjust; adjust wins over a mapped write of the same pointer
      ptr_first <= adj_val;
    else if (wr_ptr && data_addr == ADDR_B_PTR)
      ptr_first <= data_wdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      ptr_second <= RST_PTR;
    else if (take && instr_mode == OAG_MODE_INDIRECT_ADJ && ptr_sel_second)
      // (RULE6) post adjust
      ptr_second <= adj_val;
    else if (wr_ptr && data_addr == ADDR_X_PTR)
      ptr_second <= data_wdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      stack_ptr <= RST_SP;
    else if (wr_ptr && data_addr == ADDR_SP_PTR)
      // (RULE3) stack pointer mapped write
      stack_ptr <= data_wdata;
  end

endmodule : oag_operand_addr

/* File: test/oag_assertions.sv */
/* Port checker for oag_operand_addr.
   Bound from the bench; one clock, synchronous active-high reset. */
`timescale 1ns/1ps
module oag_assertions
  import oag_pkg::*;
(
  input wire logic               core_clk,       // clock
  input wire logic               sys_rst,        // reset
  input wire logic               instr_valid,    // instr present
  input wire oag_pkg::oag_mode_t instr_mode,     // mode
  input wire logic [14:0]        pc,             // opcode address
  input wire logic [7:0]         instr_addr,     // direct byte
  input wire logic [3:0]         instr_nibble,   // short value
  input wire logic               adj_down,       // step down
  input wire logic               ptr_sel_second, // pointer pick
  input wire logic [7:0]         prog_rdata,     // rom data
  input wire logic [14:0]        prog_addr,      // rom address
  input wire logic [7:0]         data_addr,      // ram address
  input wire logic               data_wr,        // ram write
  input wire logic               instr_illegal,  // refused
  input wire logic [7:0]         acc,            // accumulator
  input wire logic [7:0]         ptr_first,      // first pointer
  input wire logic [7:0]         ptr_second      // second pointer
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic ok;
  assign ok = instr_valid && !instr_illegal;
  // ==========
  // address and register checks
  property p_direct; ok && instr_mode == OAG_MODE_DIRECT |-> data_addr == instr_addr; endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");
  property p_indir; ok && instr_mode == OAG_MODE_INDIRECT
    |-> data_addr == (ptr_sel_second ? ptr_second : ptr_first); endproperty
  a_indir: assert property (p_indir) else $error("indirect address wrong");
  property p_adj; ok && instr_mode == OAG_MODE_INDIRECT_ADJ && !ptr_sel_second
    |-> data_addr == ptr_first ##1
    ptr_first == ($past(adj_down) ? $past(ptr_first) - ONE_8 : $past(ptr_first) + ONE_8);
  endproperty
  a_adj: assert property (p_adj) else $error("pointer step wrong");
  property p_adj2; ok && instr_mode == OAG_MODE_INDIRECT_ADJ && ptr_sel_second
    |-> data_addr == ptr_second ##1
    ptr_second == ($past(adj_down) ? $past(ptr_second) - ONE_8 : $past(ptr_second) + ONE_8);
  endproperty
  a_adj2: assert property (p_adj2) else $error("second pointer step wrong");
  property p_imm; ok && instr_mode == OAG_MODE_IMMEDIATE |-> prog_addr == pc + 15'h0001; endproperty
  a_imm: assert property (p_imm) else $error("immediate address wrong");
  property p_short; ok && instr_mode == OAG_MODE_IMM_SHORT
    |=> ptr_first == {HI_NIB_CLEAR, $past(instr_nibble)}; endproperty
  a_short: assert property (p_short) else $error("short load wrong");
  property p_tbl_a; ok && instr_mode == OAG_MODE_TABLE |-> prog_addr == {pc[14:8], acc}; endproperty
  a_tbl_a: assert property (p_tbl_a) else $error("table address wrong");
  property p_tbl_d; ok && instr_mode == OAG_MODE_TABLE |=> acc == $past(prog_rdata); endproperty
  a_tbl_d: assert property (p_tbl_d) else $error("table data wrong");
  property p_none; instr_valid && instr_mode == OAG_MODE_NONE |-> instr_illegal; endproperty
  a_none: assert property (p_none) else $error("no-mode not refused");
  property p_refuse; instr_valid && instr_illegal
    |-> !data_wr ##1 ($stable(acc) && $stable(ptr_first) && $stable(ptr_second)); endproperty
  a_refuse: assert property (p_refuse) else $error("refused instr had effect");
endmodule : oag_assertions

/* File: test/oag_mem_model.sv */
/* Program rom and data ram answering in the same cycle.
   Unread ram data shows the inverse, so a missing strobe is seen. */
`timescale 1ns/1ps
module oag_mem_model
(
  input wire logic        core_clk,   // clock
  input wire logic [14:0] prog_addr,  // rom address
  input wire logic [7:0]  data_addr,  // ram address
  input wire logic        data_rd,    // ram read
  input wire logic        data_wr,    // ram write
  input wire logic [7:0]  data_wdata, // ram write data
  output logic [7:0]      prog_rdata, // rom data
  output logic [7:0]      data_rdata  // ram data
);
  logic [7:0] dm [256];
  initial for (int i = 0; i < 256; i++) dm[i] = i[7:0] ^ 8'hA5;
  always @(posedge core_clk) if (data_wr) dm[data_addr] <= data_wdata;
  assign data_rdata = data_rd ? dm[data_addr] : ~dm[data_addr];
  assign prog_rdata = prog_addr[7:0] + {1'b0, prog_addr[14:8]};
endmodule : oag_mem_model

/* File: test/oag_operand_addr_bench.sv */
/* Self-checking bench for oag_operand_addr with oag_mem_model.
   State is compared one edge after each instruction. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_errors++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module oag_operand_addr_bench;
  import oag_pkg::*;
  logic core_clk = 0, sys_rst = 1, instr_valid = 0, ptr_sel_second = 0, adj_down = 0, vd = 0;
  oag_mode_t instr_mode = OAG_MODE_NONE;
  oag_op_t instr_op = OAG_OP_LOAD;
  logic [7:0] instr_addr = 8'h00, prog_rdata, data_rdata, data_addr, data_wdata;
  logic [7:0] acc, ptr_first, ptr_second, stack_ptr, e_acc = 8'h00, e_p1 = 8'h00, e_p2 = 8'h00;
  logic [7:0] e_sp = RST_SP;
  logic bt = 1'b0, il = 1'b0;
  logic [7:0] sm [256];
  logic [3:0] instr_nibble = 4'h0;
  logic [2:0] bit_index = 3'h0;
  logic [14:0] pc = 15'h0000, prog_addr;
  logic data_rd, data_wr, bit_result, instr_illegal;
  logic [33:0] q [$];
  logic [33:0] ex;
  logic [31:0] seed = 32'h1C2693F4;
  int n_errors = 0, checks_done = 0;
  oag_operand_addr oag_operand_addr_inst (.*);
  oag_mem_model oag_mem_model_inst (.*);
  always #5 core_clk = ~core_clk;
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  function automatic logic [7:0] rom(logic [14:0] x);
    return x[7:0] + {1'b0, x[14:8]};
  endfunction : rom
  // ==========
  // driver: one instruction a cycle, expectation noted first
  task automatic run(oag_mode_t m, oag_op_t o, logic s, logic d, logic [7:0] a);
    logic [7:0] p;
    logic [7:0] mb;
    logic [14:0] pv;
    logic ok;
    logic tb;
    seed = xs(seed);
    pv = seed[14:0];
    tb = 1'b0;
    p = s ? e_p2 : e_p1;
    mb = sm[(m == OAG_MODE_DIRECT) ? a : p];
    ok = !(m == OAG_MODE_NONE || (m >= OAG_MODE_IMMEDIATE && o != OAG_OP_LOAD)
      || (m == OAG_MODE_INDIRECT_ADJ && o != OAG_OP_LOAD && o != OAG_OP_EXCHANGE));
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_mode <= m;
    instr_op <= o;
    ptr_sel_second <= s;
    adj_down <= d;
    instr_addr <= a;
    instr_nibble <= a[3:0];
    bit_index <= a[6:4];
    pc <= pv;
    if (ok)
      case (m)
        OAG_MODE_DIRECT:
          case (o)
            OAG_OP_BIT_SET: sm[a] = mb | (8'h01 << a[6:4]);
            OAG_OP_BIT_CLEAR: sm[a] = mb & ~(8'h01 << a[6:4]);
            OAG_OP_BIT_TEST: tb = mb[a[6:4]];
            OAG_OP_STORE: if (a == ADDR_SP_PTR) e_sp = e_acc; else sm[a] = e_acc;
            default: e_acc = mb;
          endcase
        OAG_MODE_IMMEDIATE: e_acc = rom(pv + 15'h0001);
        OAG_MODE_IMM_SHORT: e_p1 = {4'h0, a[3:0]};
        OAG_MODE_TABLE: e_acc = rom({pv[14:8], e_acc});
        default:
        begin
          if (o == OAG_OP_EXCHANGE) sm[p] = e_acc;
          e_acc = mb;
          if (m == OAG_MODE_INDIRECT_ADJ && !s) e_p1 = d ? e_p1 - 8'h01 : e_p1 + 8'h01;
          if (m == OAG_MODE_INDIRECT_ADJ && s) e_p2 = d ? e_p2 - 8'h01 : e_p2 + 8'h01;
        end
      endcase
    q.push_back({e_acc, e_p1, e_p2, e_sp, tb, !ok});
  endtask : run
  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // ==========
  // monitor: a result shows one edge after a valid cycle
  // bit result and refusal stand only in the instruction's own cycle
  always @(posedge core_clk)
  begin
    vd <= instr_valid;
    bt <= bit_result;
    il <= instr_illegal;
  end
  always @(negedge core_clk)
    if (vd)
    begin
      if (q.size() == 0)
      begin
        n_errors++;
        $display("Error queue expected entry seen none");
      end
      else
      begin
        ex = q.pop_front();
        `CHK("state", ex, {acc, ptr_first, ptr_second, stack_ptr, bt, il})
      end
    end
  initial
  begin
    for (int i = 0; i < 256; i++) sm[i] = i[7:0] ^ 8'hA5;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    `CHK("reset", {RST_ACC, RST_PTR, RST_PTR, RST_SP}, {acc, ptr_first, ptr_second, stack_ptr})
    repeat (4)
    begin
      seed = xs(seed);
      run(OAG_MODE_IMM_SHORT, OAG_OP_LOAD, 1'b0, 1'b0, seed[7:0]);
      run(OAG_MODE_DIRECT, OAG_OP_LOAD, 1'b0, 1'b0, seed[15:8] & 8'h7F);
      run(OAG_MODE_INDIRECT_ADJ, OAG_OP_EXCHANGE, 1'b0, 1'b0, 8'h00);
      run(OAG_MODE_IMM_SHORT, OAG_OP_LOAD, 1'b0, 1'b0, 8'h00);
      run(OAG_MODE_INDIRECT_ADJ, OAG_OP_LOAD, 1'b0, 1'b1, 8'h00);
      run(OAG_MODE_INDIRECT_ADJ, OAG_OP_LOAD, 1'b0, 1'b0, 8'h00);
      run(OAG_MODE_INDIRECT, OAG_OP_EXCHANGE, 1'b1, 1'b0, 8'h00);
      run(OAG_MODE_INDIRECT_ADJ, OAG_OP_LOAD, 1'b1, 1'b0, 8'h00);
      run(OAG_MODE_DIRECT, OAG_OP_BIT_SET, 1'b0, 1'b0, seed[23:16] & 8'h7F);
      run(OAG_MODE_DIRECT, OAG_OP_BIT_TEST, 1'b0, 1'b0, seed[23:16] & 8'h7F);
      run(OAG_MODE_DIRECT, OAG_OP_LOAD, 1'b0, 1'b0, seed[23:16] & 8'h7F);
      run(OAG_MODE_DIRECT, OAG_OP_BIT_CLEAR, 1'b0, 1'b0, seed[23:16] & 8'h7F);
      run(OAG_MODE_DIRECT, OAG_OP_BIT_TEST, 1'b0, 1'b0, seed[23:16] & 8'h7F);
      run(OAG_MODE_DIRECT, OAG_OP_STORE, 1'b0, 1'b0, ADDR_SP_PTR);
      run(OAG_MODE_INDIRECT_ADJ, OAG_OP_BIT_SET, 1'b0, 1'b0, 8'h00);
      run(OAG_MODE_IMMEDIATE, OAG_OP_LOAD, 1'b0, 1'b0, 8'h00);
      run(OAG_MODE_TABLE, OAG_OP_LOAD, 1'b0, 1'b0, 8'h00);
      run(OAG_MODE_IMMEDIATE, OAG_OP_EXCHANGE, 1'b0, 1'b0, 8'h00);
      run(OAG_MODE_NONE, OAG_OP_LOAD, 1'b0, 1'b0, 8'h00);
    end
    @(posedge core_clk);
    instr_valid <= 1'b0;
    for (int i = 0; i < 8 && q.size() > 0; i++) @(posedge core_clk);
    if (q.size() > 0)
    begin
      n_errors++;
      $display("Error drain expected 0 seen %0d", q.size());
    end
    wrap_up();
  end
endmodule : oag_operand_addr_bench
bind oag_operand_addr oag_assertions oag_assertions_inst (.*);
